// [dv/ttm_pin_model.sv]
/*
  Far side model: event or gate source on the timer input pin.
  Assumes the bench calls pulse() just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ttm_pin_model (
  input wire logic i_mclk,
  input wire logic i_loop,
  input wire logic i_out_pin,
  input wire logic i_out_oe,
  output logic o_pin
);
  logic lvl_r = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Loop back to the output pin; pulled up while nobody drives it
  assign o_pin = i_loop ? (i_out_oe ? i_out_pin : 1'b1) : lvl_r;

  // Low phase then high phase; callers keep both at three cycles or more
  task automatic pulse(input int lo, input int hi);
    lvl_r <= 1'b0;
    repeat (lo) @(posedge i_mclk);
    lvl_r <= 1'b1;
    repeat (hi) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// [dv/ttm_timer_input_tb_top.sv]
/*
  Self-checking bench for the timer input block: mode table, reset,
  register access and cascading through the output pin.
  Assumes the package constants and a 40 MHz master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ttm_timer_input_tb_top;
  import ttm_pkg::*;
  typedef struct {
    logic [7:0] ps1, tmc, cnt;
    int np, lo, per, wt, nt1;
    logic en;
    int lat, ecnt;
  } ttm_row_s;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  ttm_avs_req_s avs = '0;
  logic [31:0] rdata;
  logic wreq, opin, ooe, ereq, t0req, t1req, timer_input_pin, p_e, p_t1;
  logic loop = 1'b0;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int last_e = 0;
  int n_e = 0;
  int n_t0 = 0;
  int n_t1 = 0;
  int lat_q[$];
  logic [7:0] q;
  int b_e, b_t0, b_t1, b_l, d;
  ttm_row_s r;
  // Ext, ext partial, ext continuous, gated, trig, retrig, trig cont,
  // retrig cont, internal source, trig disabled
  ttm_row_s rows[10] = '{
    '{8'h04, 8'h0c, 8'h05, 5, 4, 8, 40, 1, 1'b0, 0, 0},
    '{8'h04, 8'h0c, 8'h05, 3, 4, 8, 40, 0, 1'b1, -1, 2},
    '{8'h05, 8'h0c, 8'h03, 6, 4, 8, 40, 2, 1'b1, 0, -1},
    '{8'h04, 8'h1c, 8'h14, 1, 40, 44, 150, 1, 1'b0, 114, -1},
    '{8'h04, 8'h28, 8'h14, 3, 4, 8, 150, 1, 1'b0, 64, -1},
    '{8'h04, 8'h38, 8'h14, 3, 4, 8, 150, 1, 1'b0, 80, -1},
    '{8'h05, 8'h28, 8'h14, 1, 4, 8, 170, 2, 1'b1, 80, -1},
    '{8'h05, 8'h38, 8'h14, 3, 4, 8, 170, 2, 1'b1, 80, -1},
    '{8'h06, 8'h2c, 8'h14, 0, 4, 8, 150, 1, 1'b0, -1, -1},
    '{8'h04, 8'h20, 8'h14, 1, 4, 8, 150, 0, 1'b0, -1, -1}
  };

  ////////////////////////////////////////////////////////////////////////////
  always #12.5 i_mclk = ~i_mclk;

  ttm_timer_input i_ttm_timer_input (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_avs(avs),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq),
    .i_input_port_pin(timer_input_pin),
    .o_output_port_pin(opin),
    .o_output_port_oe(ooe),
    .o_input_edge_request(ereq),
    .o_timer_zero_request(t0req),
    .o_timer_one_request(t1req)
  );

  ttm_pin_model i_ttm_pin_model (
    .i_mclk(i_mclk),
    .i_loop(loop),
    .i_out_pin(opin),
    .i_out_oe(ooe),
    .o_pin(timer_input_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    avs.address <= {idx, 2'b00};
    avs.write <= w;
    avs.read <= ~w;
    avs.writedata <= {24'h0, wd};
    avs.byteenable <= 4'hf;
    // Values read at the edge are those it samples; only the watchdog
    // ends a wait that never gets an answer
    do begin
      @(posedge i_mclk);
    end while (wreq !== 1'b0);
    q = rdata[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    // One idle edge, so the next call never re-raises in this time step
    @(posedge i_mclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx,
                     input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Request monitor; flops are read before their edge updates land
  always @(posedge i_mclk) begin
    if (ereq === 1'b1) begin
      n_e++;
      last_e = cyc;
    end
    if (t0req === 1'b1) n_t0++;
    if (t1req === 1'b1) begin
      n_t1++;
      lat_q.push_back(cyc - last_e);
    end
    if (((ereq & p_e) | (t1req & p_t1)) === 1'b1) chk("pulse len", 0, 1);
    p_e = ereq;
    p_t1 = t1req;
    cyc++;
  end

  // Watchdog sized well above the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rdc("mode reset", TMC_IDX, TMC_RST);
    rdc("ps1 read", PS1_IDX, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    chk("oe reset", 0, {31'h0, ooe});
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, TMC_IDX, 8'h00);
      bus(1'b1, PS1_IDX, r.ps1);
      bus(1'b1, CNT1_IDX, r.cnt);
      b_e = n_e;
      b_t1 = n_t1;
      b_l = lat_q.size();
      bus(1'b1, TMC_IDX, r.tmc);
      repeat (r.np) i_ttm_pin_model.pulse(r.lo, r.per - r.lo);
      repeat (r.wt) @(posedge i_mclk);
      chk("edge reqs", r.np, n_e - b_e);
      chk("t1 reqs", r.nt1, n_t1 - b_t1);
      bus(1'b0, TMC_IDX, 8'h00);
      chk("enable", {31'h0, r.en}, {31'h0, q[TMC_EN1]});
      if (r.ecnt >= 0) rdc("count", CNT1_IDX, 8'(r.ecnt));
      if (r.lat >= 0 && lat_q.size() > b_l) begin
        d = lat_q[b_l] - r.lat;
        chk("latency", 1, {31'h0, d >= -8 && d <= 8});
      end
      $display("test row %0d done", i);
    end
    // Cascade: timer zero toggles the output, looped to the input pin
    bus(1'b1, TMC_IDX, 8'h00);
    loop <= 1'b1;
    bus(1'b1, PS0_IDX, 8'h05);
    bus(1'b1, CNT0_IDX, 8'h02);
    bus(1'b1, PS1_IDX, 8'h04);
    bus(1'b1, CNT1_IDX, 8'h03);
    bus(1'b1, P3M_IDX, 8'h00);
    b_e = n_e;
    b_t0 = n_t0;
    b_t1 = n_t1;
    bus(1'b1, TMC_IDX, 8'h4f);
    // Enable is registered one edge after the mode write lands
    @(negedge i_mclk);
    chk("oe on", 1, {31'h0, ooe});
    for (int k = 0; k < 400 && n_t1 == b_t1; k++) @(negedge i_mclk);
    // Output starts high after load, so it falls on ends 1, 3 and 5
    chk("t0 ends per t1", 5, n_t0 - b_t0);
    chk("cascade edges", 3, n_e - b_e);
    $display("test cascade done");
    // Clock output mode: the pin inverts on every master clock
    bus(1'b1, TMC_IDX, 8'hc0);
    @(negedge i_mclk);
    q[0] = opin;
    @(negedge i_mclk);
    chk("clock out", {31'h0, ~q[0]}, {31'h0, opin});
    $display("test clock out done");
    // Second reset in mid-run
    @(posedge i_mclk);
    i_arst_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    loop <= 1'b0;
    repeat (3) @(posedge i_mclk);
    rdc("mode rerst", TMC_IDX, TMC_RST);
    chk("oe rerst", 0, {31'h0, ooe});
    $display("test rereset done");
    // Reset source is external: with a quiet pin, internal ticks that
    // would end a 64 x 1 count within 260 cycles must not move it
    b_t1 = n_t1;
    bus(1'b1, CNT1_IDX, 8'h01);
    bus(1'b1, TMC_IDX, 8'h0c);
    repeat (300) @(posedge i_mclk);
    chk("reset source", 0, n_t1 - b_t1);
    $display("test reset source done");
    print_verdict();
  end
endmodule
`default_nettype wire

// [rtl/ttm_countdown.sv]
/*
  One counter/timer: 6-bit prescaler feeding an 8-bit down counter.
  Assumes load, tick and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ttm_countdown (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic i_continuous,
  input wire logic [5:0] i_pre_init,
  input wire logic [7:0] i_cnt_init,
  output logic [7:0] o_count,
  output logic o_eoc
);
  import ttm_pkg::*;

  logic [5:0] pre_r;
  logic [7:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Zero loads act as 64 and 256 since the counts wrap before reaching 1
  wire step = i_tick & i_enable & ~i_load;
  wire pre_end = (pre_r == 6'h01);
  wire cnt_end = (cnt_r == 8'h01);
  assign o_eoc = step & pre_end & cnt_end;
  assign o_count = cnt_r;

  // Load beats counting, so a load acts as a restart
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_r <= 6'h00;
      cnt_r <= CNT_RST;
    end else if (i_load) begin
      pre_r <= i_pre_init;
      cnt_r <= i_cnt_init;
    end else if (step && pre_end) begin
      pre_r <= i_pre_init;
      if (cnt_end) begin
        cnt_r <= i_continuous ? i_cnt_init : 8'h00;
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end else if (step) begin
      pre_r <= pre_r - 6'h01;
    end
  end

endmodule
`default_nettype wire

// [rtl/ttm_pkg.sv]
/*
  Shared constants and types for the timer input block: register indices,
  field positions, reset values, timing counts, modes and bus carrier.
  Assumes a 40 MHz timer master clock and a 32-bit Avalon-MM register bus.
*/
package ttm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] TMC_IDX = 8'hf1;
  localparam logic [7:0] PS1_IDX = 8'hf3;
  localparam logic [7:0] PS0_IDX = 8'hf5;
  localparam logic [7:0] P3M_IDX = 8'hf7;
  localparam logic [7:0] CNT1_IDX = 8'he2;
  localparam logic [7:0] CNT0_IDX = 8'he4;
  localparam int unsigned ADDR_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Timer mode control fields
  localparam int unsigned TMC_LD0 = 0;
  localparam int unsigned TMC_EN0 = 1;
  localparam int unsigned TMC_LD1 = 2;
  localparam int unsigned TMC_EN1 = 3;
  localparam int unsigned TMC_TIN_LO = 4;
  localparam int unsigned TMC_TOUT_LO = 6;
  // Prescaler setup fields
  localparam int unsigned PS_MODE_BIT = 0;
  localparam int unsigned PS1_SRC_BIT = 1;
  localparam int unsigned PS_VAL_LO = 2;
  // Port three mode: 0 makes the output pin an output unless the output mode is off
  localparam int unsigned P3M_OUT_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] TMC_RST = 8'h00;
  localparam logic [7:0] PS1_RST = 8'h00;
  localparam logic [7:0] PS0_RST = 8'h00;
  localparam logic [7:0] P3M_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: internal timer clock is four master clock periods
  localparam int unsigned MCLK_NS = 25;
  localparam int unsigned TCLK_NS = 100;
  localparam int unsigned TCLK_CYC = TCLK_NS / MCLK_NS;
  localparam logic [1:0] TCLK_LAST = 2'(TCLK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input pin modes and output pin modes
  localparam logic [1:0] TIN_EXT = 2'h0;
  localparam logic [1:0] TIN_GATE = 2'h1;
  localparam logic [1:0] TIN_TRIG = 2'h2;
  localparam logic [1:0] TIN_RETRIG = 2'h3;
  localparam logic [1:0] TOUT_OFF = 2'h0;
  localparam logic [1:0] TOUT_T0 = 2'h1;
  localparam logic [1:0] TOUT_T1 = 2'h2;
  localparam logic [1:0] TOUT_CLK = 2'h3;

  typedef enum logic [0:0] {T1_IDLE, T1_RUN} ttm_t1_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ttm_avs_req_s;

endpackage

// [rtl/ttm_timer_input.sv]
/*
  Two counter/timers with the timer input pin modes for timer one, the
  toggle output pin and an Avalon-MM register slave with waitrequest.
  Assumes the input pin is asynchronous; all logic runs on i_mclk.
*/
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ttm_timer_input (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire ttm_pkg::ttm_avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_input_port_pin,
  output logic o_output_port_pin,
  output logic o_output_port_oe,
  output logic o_input_edge_request,
  output logic o_timer_zero_request,
  output logic o_timer_one_request
);
  import ttm_pkg::*;

  logic [7:0] tmc_r;
  logic [7:0] tmc_nxt;
  logic [7:0] ps0_r;
  logic [7:0] ps1_r;
  logic [7:0] p3m_r;
  logic [7:0] cnt0_init_r;
  logic [7:0] cnt1_init_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic [1:0] tdiv_r;
  ttm_t1_state_e t1_st_r;
  ttm_t1_state_e t1_st_nxt;
  logic edge_req_r;
  logic t0_req_r;
  logic t1_req_r;
  logic tout_r;
  logic clkout_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic [7:0] t0_count;
  logic [7:0] t1_count;
  logic t0_eoc;
  logic t1_eoc;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: first cycle of a request stalls, second one completes
  wire req = i_avs.read | i_avs.write;
  wire acc = req & ack_r;
  wire [7:0] idx = i_avs.address[ADDR_W-1:2];
  wire wr_lo = acc & i_avs.write & i_avs.byteenable[0];
  wire [7:0] wdat = i_avs.writedata[7:0];
  wire wr_tmc = wr_lo & (idx == TMC_IDX);
  wire wr_ps0 = wr_lo & (idx == PS0_IDX);
  wire wr_ps1 = wr_lo & (idx == PS1_IDX);
  wire wr_p3m = wr_lo & (idx == P3M_IDX);
  wire wr_cnt0 = wr_lo & (idx == CNT0_IDX);
  wire wr_cnt1 = wr_lo & (idx == CNT1_IDX);
  assign o_avs_waitrequest = req & ~ack_r;
  assign o_avs_readdata = rdata_r;

  // Prescalers are write-only and read as zero like unmapped words
  wire [7:0] rd_byte = (idx == TMC_IDX) ? tmc_r :
                       (idx == P3M_IDX) ? p3m_r :
                       (idx == CNT0_IDX) ? t0_count :
                       (idx == CNT1_IDX) ? t1_count : 8'h00;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ps0_r <= PS0_RST;
      ps1_r <= PS1_RST;
      p3m_r <= P3M_RST;
      cnt0_init_r <= CNT_RST;
      cnt1_init_r <= CNT_RST;
    end else begin
      if (wr_ps0) ps0_r <= wdat;
      if (wr_ps1) ps1_r <= wdat;
      if (wr_p3m) p3m_r <= wdat;
      if (wr_cnt0) cnt0_init_r <= wdat;
      if (wr_cnt1) cnt1_init_r <= wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input pin: two-stage synchroniser, third stage for edge detection
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
    end else begin
      pin_s1_r <= i_input_port_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  wire fall = pin_s3_r & ~pin_s2_r;

  // Internal timer clock tick, one master cycle in four
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tdiv_r <= 2'h0;
    end else begin
      tdiv_r <= tdiv_r + 2'h1;
    end
  end
  wire tick4 = (tdiv_r == TCLK_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Timer one source and input pin mode selection
  wire t1_ext = ~ps1_r[PS1_SRC_BIT];
  wire [1:0] tin_mode = tmc_r[TMC_TIN_LO +: 2];
  wire en1 = tmc_r[TMC_EN1];
  wire t1_cont = ps1_r[PS_MODE_BIT];
  wire trig_mode = t1_ext & tin_mode[1];
  wire retrig = tin_mode == TIN_RETRIG;
  // Triggered mode fires once from idle; retriggerable fires every edge
  wire trig_fire = trig_mode & en1 & fall &
                   (retrig | (t1_st_r == T1_IDLE));
  // Software load covers clock and gate modes, edge covers trigger modes
  wire t1_load = tmc_r[TMC_LD1] | trig_fire;
  wire t1_run = t1_st_r == T1_RUN;
  // External edge decrements at once, with no four-clock start delay
  wire t1_tick = !t1_ext ? tick4 :
                 (tin_mode == TIN_EXT) ? fall :
                 (tin_mode == TIN_GATE) ? tick4 & pin_s2_r :
                 tick4 & t1_run;

  // Trigger state: idle until the edge, back to idle on disable or single-pass end
  always_comb begin
    t1_st_nxt = t1_st_r;
    if (!en1) begin
      t1_st_nxt = T1_IDLE;
    end else if (trig_fire) begin
      t1_st_nxt = T1_RUN;
    end else if (t1_eoc && !t1_cont) begin
      t1_st_nxt = T1_IDLE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t1_st_r <= T1_IDLE;
    end else begin
      t1_st_r <= t1_st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control: load bits last one cycle; single-pass end drops enable.
  // A software write wins so a fresh enable is never lost.
  always_comb begin
    tmc_nxt = tmc_r;
    tmc_nxt[TMC_LD0] = 1'b0;
    tmc_nxt[TMC_LD1] = 1'b0;
    if (t0_eoc && !ps0_r[PS_MODE_BIT]) begin
      tmc_nxt[TMC_EN0] = 1'b0;
    end
    if (t1_eoc && !t1_cont) begin
      tmc_nxt[TMC_EN1] = 1'b0;
    end
    if (wr_tmc) begin
      tmc_nxt = wdat;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmc_r <= TMC_RST;
    end else begin
      tmc_r <= tmc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The two counter/timers
  ttm_countdown u_timer_zero (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_load(tmc_r[TMC_LD0]),
    .i_tick(tick4),
    .i_enable(tmc_r[TMC_EN0]),
    .i_continuous(ps0_r[PS_MODE_BIT]),
    .i_pre_init(ps0_r[7:PS_VAL_LO]),
    .i_cnt_init(cnt0_init_r),
    .o_count(t0_count),
    .o_eoc(t0_eoc)
  );

  ttm_countdown u_timer_one (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_load(t1_load),
    .i_tick(t1_tick),
    .i_enable(en1),
    .i_continuous(t1_cont),
    .i_pre_init(ps1_r[7:PS_VAL_LO]),
    .i_cnt_init(cnt1_init_r),
    .o_count(t1_count),
    .o_eoc(t1_eoc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Requests, one registered pulse per event
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      edge_req_r <= 1'b0;
      t0_req_r <= 1'b0;
      t1_req_r <= 1'b0;
    end else begin
      edge_req_r <= fall;
      t0_req_r <= t0_eoc;
      t1_req_r <= t1_eoc;
    end
  end
  assign o_input_edge_request = edge_req_r;
  assign o_timer_zero_request = t0_req_r;
  assign o_timer_one_request = t1_req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output pin: toggles at each end of the selected timer, so a
  // continuous timer zero falls every second end when wired back
  wire [1:0] tout_mode = tmc_r[TMC_TOUT_LO +: 2];
  wire tout_init = ((tout_mode == TOUT_T0) & tmc_r[TMC_LD0]) |
                   ((tout_mode == TOUT_T1) & tmc_r[TMC_LD1]);
  wire tout_flip = ((tout_mode == TOUT_T0) & t0_eoc) |
                   ((tout_mode == TOUT_T1) & t1_eoc);
  wire pin_out_nxt = (tout_mode == TOUT_CLK) ? clkout_r : tout_r;
  wire pin_oe_nxt = (tout_mode != TOUT_OFF) & ~p3m_r[P3M_OUT_BIT];

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tout_r <= 1'b1;
      clkout_r <= 1'b0;
      pin_out_r <= 1'b1;
      pin_oe_r <= 1'b0;
    end else begin
      if (tout_init) begin
        tout_r <= 1'b1;
      end else if (tout_flip) begin
        tout_r <= ~tout_r;
      end
      clkout_r <= ~clkout_r;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end
  assign o_output_port_pin = pin_out_r;
  assign o_output_port_oe = pin_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_retrig_edge;
    t1_ext && retrig && en1 && fall;
  endsequence
  sequence seq_t1_reloaded;
    t1_count == $past(cnt1_init_r);
  endsequence

  AST_EDGE_REQ: assert property (
    fall |=> o_input_edge_request ##1 !o_input_edge_request)
    else $error("falling edge did not give one request pulse");
  AST_EDGE_CAUSE: assert property (
    o_input_edge_request |-> $past(pin_s3_r) && !$past(pin_s2_r))
    else $error("edge request without a synchronised falling edge");
  AST_T1_PULSE: assert property (
    o_timer_one_request |=> !o_timer_one_request)
    else $error("timer one request longer than one cycle");
  AST_EXT_HOLD: assert property (
    (t1_ext && tin_mode == TIN_EXT && !fall && !t1_load) |=>
    $stable(t1_count))
    else $error("external mode counted without an input edge");
  AST_GATE_HOLD: assert property (
    (t1_ext && tin_mode == TIN_GATE && !pin_s2_r && !t1_load) |=>
    $stable(t1_count))
    else $error("gated timer moved while the pin was low");
  AST_SP_CLEAR: assert property (
    (t1_eoc && !t1_cont && !wr_tmc) |=> !tmc_r[TMC_EN1] && !t1_run)
    else $error("single-pass end did not clear the enable");
  AST_TRIG_IGNORE: assert property (
    (t1_ext && tin_mode == TIN_TRIG && t1_run && fall &&
     !tmc_r[TMC_LD1]) |=> $stable(t1_st_r) || !en1)
    else $error("triggered timer reacted to a later edge");
  AST_RETRIG_LOAD: assert property (
    seq_retrig_edge |=> seq_t1_reloaded ##0 t1_run)
    else $error("retrigger edge did not reload and start timer one");
  AST_T1_EOC_REQ: assert property (
    t1_eoc |=> o_timer_one_request)
    else $error("end-of-count gave no timer one request");
  AST_DISABLED_HOLD: assert property (
    (!en1 && !t1_load) [*2] |-> $stable(t1_count))
    else $error("timer one moved while disabled");
  AST_BUS_ANSWER: assert property (
    (req && !ack_r) |=> !o_avs_waitrequest)
    else $error("bus request stalled more than one cycle");

endmodule
`default_nettype wire
